// File: core/scom_top.v
// serial controlled five bit output mux with one latched non-muxed output
// assumes the two-wire master supplies the serial clock; all pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "scom_regs.vh"

// Overview of operation
// - the serial port is a two-wire slave only and works at both 100 and 400 kbit/s.
// - only one 7-bit address answers, 1001110 with address select high, else 0110111.
// - after reset the route select code is 10 so the muxed outputs pass the parallel inputs.
// - code 00 passes stored register A, 01 stored register B, 10 the parallel inputs.
// - a newly written route takes effect only at the next stop condition.
// - with the force-low pin at 0 every output, muxed and non-muxed, is 0.
// - with write protect at 1 serial writes are ignored and stored values kept.
// - routing pin 0 drives the muxed outputs from the source the route select code picks, 1 from the inputs.
// - the non-muxed latch is transparent with routing pin 0 and route code 00 or 01, and holds otherwise.
// - registers are A at 00H and B at 01H read/write, and input capture at 02H read only.
// - input capture holds the 5-bit parallel input value and writes never change it.
// - stored byte bits 7:6 are route select, bit 4 the non-muxed bit, bits 5,3:0 data.
// - a write is address plus one byte whose top two bits pick A or B, low six the data.
// - a read returns A, B, then input capture, and the master may stop after A.
// - a write reaches the stored register only after the 10 ms non-volatile update.
// - input capture samples the inputs on the first serial clock after a start.
module scom_top #(
	parameter NV_CYCLES = `SCOM_NV_CYCLES,
	parameter NV_W      = 18
) (
	// clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// two-wire serial link
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output wire       sda_oe_o,
	// configuration pins
	input  wire       slave_address_select_i,
	input  wire       force_low_pin_n_i,
	input  wire       write_protect_i,
	input  wire       routing_select_pin_i,
	// parallel port
	input  wire [4:0] par_in_i,
	output wire [4:0] mux_out_o,
	output wire       non_mux_out_o
);

	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_AACK = 7'h04;
	localparam [6:0] ST_WR   = 7'h08;
	localparam [6:0] ST_WACK = 7'h10;
	localparam [6:0] ST_RD   = 7'h20;
	localparam [6:0] ST_RACK = 7'h40;
	localparam integer    NV_LAST_I = NV_CYCLES - 1;
	localparam [NV_W-1:0] NV_LAST   = NV_LAST_I[NV_W-1:0];

	wire [10:0] pins;
	scom_pin_sync #(
		.W    (11),
		.INIT (11'h680)
	) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({scl_i, sda_i, slave_address_select_i, force_low_pin_n_i,
			write_protect_i, routing_select_pin_i, par_in_i}),
		.q_o    (pins)
	);
	wire       scl       = pins[10];
	wire       sda       = pins[9];
	wire       slave_address_select      = pins[8];
	wire       force_n   = pins[7];
	wire       wp        = pins[6];
	wire       route_pin = pins[5];
	wire [4:0] pin_in    = pins[4:0];

	reg        scl_p_q;
	reg        sda_p_q;
	reg  [6:0] state_q;
	reg  [3:0] cnt_q;
	reg  [7:0] shift_q;
	reg  [1:0] idx_q;
	reg        sda_oe_q;
	reg        cap_pend_q;
	reg  [4:0] input_capture_q;
	reg  [5:0] stored_output_a_q;
	reg  [5:0] stored_output_b_q;
	reg  [1:0] route_q;
	reg  [1:0] route_pend_q;
	reg        route_pend_v_q;
	reg        nv_busy_q;
	reg        nv_dest_q;
	reg  [5:0] nv_data_q;
	reg  [NV_W-1:0] nv_cnt_q;
	reg  [4:0] mux_q;
	reg        nmo_latch_q;
	reg        nmo_q;

	wire scl_rise = scl & ~scl_p_q;
	wire scl_fall = ~scl & scl_p_q;
	wire start_ev = scl & scl_p_q & sda_p_q & ~sda;
	wire stop_ev  = scl & scl_p_q & ~sda_p_q & sda;
	wire [6:0] my_addr = slave_address_select ? `SCOM_ADDR_SEL_HIGH : `SCOM_ADDR_SEL_LOW;

	reg [7:0] rd_byte;
	always @*
	begin
		case (idx_q)
			`SCOM_IDX_STORED_OUTPUT_A: rd_byte = {2'h0, stored_output_a_q};
			`SCOM_IDX_STORED_OUTPUT_B: rd_byte = {2'h0, stored_output_b_q};
			default:                   rd_byte = {3'h0, input_capture_q};
		endcase
	end

	// serial slave: shift on clock rise, drive on clock fall
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_p_q         <= 1'b1;
			sda_p_q         <= 1'b1;
			state_q         <= ST_IDLE;
			cnt_q           <= 4'h0;
			shift_q         <= 8'h00;
			idx_q           <= 2'h0;
			sda_oe_q        <= 1'b0;
			cap_pend_q      <= 1'b0;
			input_capture_q <= 5'h00;
			route_q         <= `SCOM_ROUTE_RESET;
			route_pend_q    <= `SCOM_ROUTE_RESET;
			route_pend_v_q  <= 1'b0;
			nv_busy_q       <= 1'b0;
			nv_dest_q       <= 1'b0;
			nv_data_q       <= 6'h00;
		end
		else
		begin
			scl_p_q <= scl;
			sda_p_q <= sda;
			// clear only on a real commit; a write ack below sets it again and wins
			if (nv_busy_q && nv_cnt_q == NV_LAST && state_q != ST_WACK)
				nv_busy_q <= 1'b0;
			if (start_ev)
			begin
				state_q    <= ST_ADDR;
				cnt_q      <= 4'h0;
				sda_oe_q   <= 1'b0;
				cap_pend_q <= 1'b1;
			end
			else if (stop_ev)
			begin
				state_q        <= ST_IDLE;
				sda_oe_q       <= 1'b0;
				route_pend_v_q <= 1'b0;
				if (route_pend_v_q)
					route_q <= route_pend_q;
			end
			else
			begin
				if (scl_rise && cap_pend_q)
				begin
					input_capture_q <= pin_in;
					cap_pend_q      <= 1'b0;
				end
				case (state_q)
					ST_IDLE:
						sda_oe_q <= 1'b0;
					ST_ADDR:
						if (scl_rise)
						begin
							shift_q <= {shift_q[6:0], sda};
							cnt_q   <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							if (shift_q[7:1] == my_addr)
							begin
								state_q  <= ST_AACK;
								sda_oe_q <= 1'b1;
								idx_q    <= `SCOM_IDX_STORED_OUTPUT_A;
							end
							else
								state_q <= ST_IDLE;
						end
					ST_AACK:
						if (scl_fall)
						begin
							cnt_q <= 4'h0;
							if (shift_q[0])
							begin
								state_q  <= ST_RD;
								shift_q  <= rd_byte;
								sda_oe_q <= ~rd_byte[7];
							end
							else
							begin
								state_q  <= ST_WR;
								sda_oe_q <= 1'b0;
							end
						end
					ST_WR:
						if (scl_rise)
						begin
							shift_q <= {shift_q[6:0], sda};
							cnt_q   <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							state_q  <= ST_WACK;
							sda_oe_q <= 1'b1;
							if (!wp)
							begin
								if (shift_q[7:6] != `SCOM_ROUTE_RESERVED)
								begin
									route_pend_q   <= shift_q[7:6];
									route_pend_v_q <= 1'b1;
								end
								if (shift_q[7] == 1'b0)
								begin
									nv_busy_q <= 1'b1;
									nv_dest_q <= shift_q[6];
									nv_data_q <= shift_q[5:0];
								end
							end
						end
					ST_WACK:
						if (scl_fall)
						begin
							state_q  <= ST_IDLE;
							sda_oe_q <= 1'b0;
						end
					ST_RD:
						if (scl_rise)
							cnt_q <= cnt_q + 4'h1;
						else if (scl_fall)
						begin
							if (cnt_q == 4'h8)
							begin
								state_q  <= ST_RACK;
								sda_oe_q <= 1'b0;
							end
							else
							begin
								shift_q  <= {shift_q[6:0], 1'b0};
								sda_oe_q <= ~shift_q[6];
							end
						end
					ST_RACK:
						if (scl_rise)
						begin
							if (sda)
								state_q <= ST_IDLE;
							else
								idx_q <= (idx_q == `SCOM_IDX_INPUT_CAPTURE) ?
									`SCOM_IDX_STORED_OUTPUT_A : idx_q + 2'h1;
						end
						else if (scl_fall)
						begin
							state_q  <= ST_RD;
							cnt_q    <= 4'h0;
							shift_q  <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// non-volatile update timer and commit
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			nv_cnt_q          <= {NV_W{1'b0}};
			stored_output_a_q <= `SCOM_STORED_RESET;
			stored_output_b_q <= `SCOM_STORED_RESET;
		end
		else if (!nv_busy_q || state_q == ST_WACK)
			nv_cnt_q <= {NV_W{1'b0}};
		else if (nv_cnt_q == NV_LAST)
		begin
			nv_cnt_q <= {NV_W{1'b0}};
			if (nv_dest_q)
				stored_output_b_q <= nv_data_q;
			else
				stored_output_a_q <= nv_data_q;
		end
		else
			nv_cnt_q <= nv_cnt_q + {{(NV_W-1){1'b0}}, 1'b1};
	end

	// output mux and non-muxed latch
	reg [5:0] sel_data;
	always @*
	begin
		case (route_q)
			`SCOM_ROUTE_STORED_A: sel_data = stored_output_a_q;
			`SCOM_ROUTE_STORED_B: sel_data = stored_output_b_q;
			default:              sel_data = {pin_in[4], 1'b0, pin_in[3:0]};
		endcase
	end

	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mux_q       <= 5'h00;
			nmo_latch_q <= 1'b0;
			nmo_q       <= 1'b0;
		end
		else
		begin
			if (!route_pin && !route_q[1])
				nmo_latch_q <= sel_data[`SCOM_FLD_NMO];
			if (!force_n)
			begin
				mux_q <= 5'h00;
				nmo_q <= 1'b0;
			end
			else
			begin
				mux_q <= route_pin ? pin_in : {sel_data[5], sel_data[3:0]};
				nmo_q <= (!route_pin && !route_q[1]) ? sel_data[`SCOM_FLD_NMO] : nmo_latch_q;
			end
		end
	end

	assign sda_o         = 1'b0;
	assign sda_oe_o      = sda_oe_q;
	assign mux_out_o     = mux_q;
	assign non_mux_out_o = nmo_q;

endmodule

`default_nettype wire

// File: core/scom_regs.vh
// register offsets, field layout, slave addresses and timing for the serial output mux
// assumes a 20 MHz core clock; included by bare name
`ifndef SCOM_REGS_VH
`define SCOM_REGS_VH

// register indices on the serial link
`define SCOM_IDX_STORED_OUTPUT_A 2'h0
`define SCOM_IDX_STORED_OUTPUT_B 2'h1
`define SCOM_IDX_INPUT_CAPTURE   2'h2

// slave addresses chosen by the address select pin
`define SCOM_ADDR_SEL_HIGH 7'h4e
`define SCOM_ADDR_SEL_LOW  7'h37

// route select codes, byte bits 7:6
`define SCOM_ROUTE_STORED_A 2'h0
`define SCOM_ROUTE_STORED_B 2'h1
`define SCOM_ROUTE_INPUTS   2'h2
`define SCOM_ROUTE_RESERVED 2'h3
`define SCOM_ROUTE_RESET    2'h2

// field positions in a stored output byte
`define SCOM_FLD_ROUTE_HI 7
`define SCOM_FLD_ROUTE_LO 6
`define SCOM_FLD_NMO      4
`define SCOM_STORED_RESET 6'h00

// non-volatile update time
`define SCOM_CLK_HZ        20000000
`define SCOM_NV_UPDATE_MS  10
`define SCOM_NV_CYCLES     (`SCOM_NV_UPDATE_MS * (`SCOM_CLK_HZ / 1000))

`endif

// File: core/scom_pin_sync.v
// three-stage pin synchroniser, one per bit
// assumes inputs come from outside the clk_i domain
`timescale 1ns/1ps
`default_nettype none

module scom_pin_sync #(
	parameter         W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         nrst_i,
	// pins in, filtered levels out
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg out_q;
			always @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					s1_q  <= INIT[g];
					s2_q  <= INIT[g];
					s3_q  <= INIT[g];
					out_q <= INIT[g];
				end
				else
				begin
					s1_q <= d_i[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// a change counts once stages two and three agree
					if (s2_q == s3_q)
						out_q <= s3_q;
				end
			end
			assign q_o[g] = out_q;
		end
	endgenerate

endmodule

`default_nettype wire

// File: tb/scom_props.sv
// concurrent checks on the serial output mux top level ports
// assumes pins stay steady across reset release
`timescale 1ns/1ps
`default_nettype none
module scom_props #(
	parameter NV_CYCLES = 200,
	parameter NV_W      = 18
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       nrst_i,
	// serial link
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	// pins
	input wire logic       slave_address_select_i,
	input wire logic       force_low_pin_n_i,
	input wire logic       write_protect_i,
	input wire logic       routing_select_pin_i,
	input wire logic [4:0] par_in_i,
	input wire logic [4:0] mux_out_o,
	input wire logic       non_mux_out_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_force_zero: assert property (
		!force_low_pin_n_i [*8] |-> mux_out_o == 5'h00 && !non_mux_out_o)
		else $error("outputs not forced low");
	chk_pin_route: assert property (
		(force_low_pin_n_i && routing_select_pin_i && $stable(par_in_i)) [*8]
		|-> mux_out_o == par_in_i) else $error("outputs not from inputs");
	chk_nmo_hold: assert property (
		(routing_select_pin_i && force_low_pin_n_i) [*8] ##1
		(routing_select_pin_i && force_low_pin_n_i) |-> $stable(non_mux_out_o))
		else $error("latched output moved");
	chk_reset_route: assert property (
		$rose(nrst_i) && force_low_pin_n_i |-> ##8 mux_out_o == par_in_i)
		else $error("default route not inputs");
	chk_oe_scl_low: assert property (
		$changed(sda_oe_o) |-> !scl_i) else $error("data changed with clock high");
	chk_sda_low: assert property (
		sda_oe_o |-> sda_o == 1'b0) else $error("data driven high");
	chk_reset_quiet: assert property (
		$rose(nrst_i) |-> !sda_oe_o [*8]) else $error("data driven after reset");
	chk_ack_hold: assert property (
		$rose(sda_oe_o) |-> sda_oe_o [*3]) else $error("data pulse too short");
endmodule
bind scom_top scom_props #(.NV_CYCLES(NV_CYCLES), .NV_W(NV_W)) scom_props_i (
	.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .slave_address_select_i(slave_address_select_i),
	.force_low_pin_n_i(force_low_pin_n_i), .write_protect_i(write_protect_i),
	.routing_select_pin_i(routing_select_pin_i), .par_in_i(par_in_i),
	.mux_out_o(mux_out_o), .non_mux_out_o(non_mux_out_o));
`default_nettype wire

// File: tb/scom_master_model.sv
// two-wire bus master: drives the clock and pulls data low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module scom_master_model (
	// wire levels
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// bit slot of 400 ns: low 300, high 100
	task automatic bit_io(input logic o, output logic i);
	begin
		#100 sda_low_o = !o;
		#200 scl_o = 1'b1;
		#100 i = sda_i;
		scl_o = 1'b0;
	end
	endtask
	task automatic start;
	begin
		#100 sda_low_o = 1'b0;
		#200 scl_o = 1'b1;
		#200 sda_low_o = 1'b1;
		#200 scl_o = 1'b0;
	end
	endtask
	task automatic stop;
	begin
		#100 sda_low_o = 1'b1;
		#200 scl_o = 1'b1;
		#200 sda_low_o = 1'b0;
		#200;
	end
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
	begin
		for (int k = 7; k >= 0; k--) bit_io(b[k], s);
		bit_io(1'b1, s);
		ack = !s;
	end
	endtask
	// last byte answered with release, ending the read
	task automatic get(input logic last, output logic [7:0] b);
		logic s;
	begin
		for (int k = 7; k >= 0; k--)
		begin
			bit_io(1'b1, s);
			b[k] = s;
		end
		bit_io(last, s);
	end
	endtask
endmodule
`default_nettype wire

// File: tb/scom_top_test.sv
// self-checking bench for the serial output mux
// assumes the master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "scom_regs.vh"
module scom_top_test;
	localparam NV = 200;
	logic       clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       slave_address_select = 1'b1;
	logic       frc_n = 1'b1;
	logic       wp = 1'b0;
	logic       rsel = 1'b0;
	logic [4:0] pin = 5'h15;
	wire        scl, sda_low, sda_oe, sda_o, nm_out;
	wire  [4:0] mux;
	wire        sda = !(sda_low || sda_oe);
	int         n_fail = 0;
	int         checks_done = 0;
	logic [7:0] rb;
	logic       ack;
	scom_top #(.NV_CYCLES(NV)) scom_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .slave_address_select_i(slave_address_select),
		.force_low_pin_n_i(frc_n), .write_protect_i(wp), .routing_select_pin_i(rsel),
		.par_in_i(pin), .mux_out_o(mux), .non_mux_out_o(nm_out));
	scom_master_model scom_master_model_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
	initial forever #25 clk_i = ~clk_i;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
	begin
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task automatic pause(input int n);
	begin
		repeat (n) @(negedge clk_i);
	end
	endtask
	task automatic outs(input logic [7:0] exp);
	begin
		chk({nm_out, 2'h0, mux}, exp);
	end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic ok);
	begin
		scom_master_model_i.start();
		scom_master_model_i.put({a, 1'b0}, ack);
		chk({7'h0, ack}, {7'h0, ok});
		if (ack)
			scom_master_model_i.put(d, ack);
		if (ok)
			chk({7'h0, ack}, 8'h01);
	end
	endtask
	task automatic wr_stop(input logic [6:0] a, input logic [7:0] d);
	begin
		wr(a, d, 1'b1);
		scom_master_model_i.stop();
		pause(NV + 20);
	end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
	begin
		scom_master_model_i.start();
		scom_master_model_i.put({`SCOM_ADDR_SEL_HIGH, 1'b1}, ack);
		scom_master_model_i.get(1'b0, rb);
		chk(rb, a);
		scom_master_model_i.get(1'b0, rb);
		chk(rb, b);
		scom_master_model_i.get(1'b1, rb);
		chk(rb, c);
		scom_master_model_i.stop();
		pause(10);
	end
	endtask
	task automatic wrap_up;
	begin
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	initial
	begin
		#1_000_000;
		n_fail++;
		wrap_up();
	end
	initial
	begin
		pause(4);
		nrst_i = 1'b1;
		pause(10);
		outs(8'h15);
		rd(8'h00, 8'h00, 8'h15);
		wr(`SCOM_ADDR_SEL_LOW, 8'h00, 1'b0);
		scom_master_model_i.stop();
		wr(`SCOM_ADDR_SEL_HIGH, 8'h2b, 1'b1);
		pause(10);
		outs(8'h15);
		scom_master_model_i.stop();
		pause(10);
		outs(8'h00);
		pause(NV);
		outs(8'h1b);
		wr_stop(`SCOM_ADDR_SEL_HIGH, 8'h54);
		outs(8'h84);
		wr_stop(`SCOM_ADDR_SEL_HIGH, 8'hff);
		outs(8'h84);
		wp = 1'b1;
		wr_stop(`SCOM_ADDR_SEL_HIGH, 8'h3f);
		outs(8'h84);
		wp = 1'b0;
		pin = 5'h0a;
		rd(8'h2b, 8'h14, 8'h0a);
		rsel = 1'b1;
		pause(10);
		outs(8'h8a);
		rsel = 1'b0;
		pause(10);
		outs(8'h84);
		frc_n = 1'b0;
		pause(10);
		outs(8'h00);
		frc_n = 1'b1;
		pause(10);
		wr_stop(`SCOM_ADDR_SEL_HIGH, 8'h80);
		outs(8'h8a);
		slave_address_select = 1'b0;
		pause(10);
		wr_stop(`SCOM_ADDR_SEL_LOW, 8'h00);
		outs(8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
